// [hdl/unmc_pkg.sv]
package unmc_pkg;

	// register word offsets (byte addresses), chosen for this block
	localparam logic [3:0] NAK_FLAG_OFS   = 4'h0;
	localparam logic [3:0] NAK_MASK_OFS   = 4'h4;
	localparam logic [3:0] EP0_SIZE_OFS   = 4'h8;
	localparam logic [3:0] IRQ_STAT_OFS   = 4'hc;
	localparam logic [3:0] CMD_OFS        = 4'h0 + 4'h0;
	localparam logic [4:0] CMD_ADDR       = 5'h10;
	localparam logic [4:0] IRQ_MASK_ADDR  = 5'h14;

	// field positions
	localparam int ZLP_PEND_BIT   = 15;
	localparam int FIFO_VALID_BIT = 12;
	localparam int MAXPKT_W       = 7;

	// command codes and reset values
	localparam logic [7:0] CMD_SEND_ZLP_EP0 = 8'h01;
	localparam logic [6:0] MAXPKT_RST       = 7'h00;
	localparam logic [7:1] MASK_RST         = 7'h00;

	// interrupt status bits
	localparam int IRQ_W       = 3;
	localparam int IRQ_NAK     = 0;
	localparam int IRQ_ZLP_DONE = 1;
	localparam int IRQ_SETUP   = 2;

	// usb side events (single-cycle pulses on core clock, except fifo_has_data, a level)
	typedef struct packed {
		logic [7:1] nak_sent;
		logic       setup_rx;
		logic       zlp_sent;
		logic       fifo_has_data;
	} unmc_usb_ev_t;

	// avalon request
	typedef struct packed {
		logic [4:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} unmc_av_req_t;

endpackage : unmc_pkg

// [hdl/unmc_irq.sv]
// sticky status, mask and level interrupt
module unmc_irq (
	// clock and reset
	input  wire logic                        core_clk_in,
	input  wire logic                        rstn_in,
	// events and software access
	input  wire logic [unmc_pkg::IRQ_W-1:0] event_in,
	input  wire logic                        stat_rd_in,
	input  wire logic                        mask_wr_in,
	input  wire logic [unmc_pkg::IRQ_W-1:0] mask_data_in,
	// state out
	output logic      [unmc_pkg::IRQ_W-1:0] stat_out,
	output logic      [unmc_pkg::IRQ_W-1:0] mask_out,
	output logic                             irq_out
);

	typedef struct packed {
		logic [unmc_pkg::IRQ_W-1:0] stat;
		logic [unmc_pkg::IRQ_W-1:0] mask;
		logic                        irq;
	} unmc_irq_st_t;

	unmc_irq_st_t st_q;
	unmc_irq_st_t st_d;

	// read clears, new events win over the clear
	always_comb begin
		st_d = st_q;
		if (stat_rd_in) begin
			st_d.stat = '0;
		end
		st_d.stat = st_d.stat | event_in;
		if (mask_wr_in) begin
			st_d.mask = mask_data_in;
		end
		st_d.irq = |(st_d.stat & ~st_d.mask);
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign stat_out = st_q.stat;
	assign mask_out = st_q.mask;
	assign irq_out  = st_q.irq;

endmodule : unmc_irq

// [hdl/unmc_ctrl.sv]
module unmc_ctrl (
	// clock and reset
	input  wire logic                  core_clk_in,
	input  wire logic                  rstn_in,
	// avalon-mm slave
	input  wire logic [4:0]            avs_address_in,
	input  wire logic                  avs_read_in,
	input  wire logic                  avs_write_in,
	input  wire logic [31:0]           avs_writedata_in,
	input  wire logic [3:0]            avs_byteenable_in,
	output logic      [31:0]           avs_readdata_out,
	output logic                       avs_waitrequest_out,
	// usb engine events
	input  wire unmc_pkg::unmc_usb_ev_t usb_ev_in,
	// outputs
	output logic                       nak_irq_pin_out,
	output logic                       irq_out
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef enum {
		UNMC_IDLE,
		UNMC_ACK
	} unmc_bus_st_t;

	typedef struct packed {
		unmc_bus_st_t bus;
		logic [31:0]  rdata;
		logic         waitreq;
		logic [7:1]   nak_flags;
		logic [7:1]   nak_pin_mask_bits;
		logic         zero_length_pending;
		logic         fifo_valid;
		logic [6:0]   max_pkt;
		logic         nak_pin;
	} unmc_st_t;

	unmc_st_t st_q;
	unmc_st_t st_d;

	// irq helper signals
	logic [unmc_pkg::IRQ_W-1:0] irq_ev;
	logic [unmc_pkg::IRQ_W-1:0] irq_stat;
	logic [unmc_pkg::IRQ_W-1:0] irq_mask;
	logic                        irq_level;
	logic                        stat_rd;
	logic                        mask_wr;
	logic                        take;
	logic [4:0]                  addr;

	////////////////////////////////////////////////////////////////////////
	// request decode

	// a request is taken once, in the idle cycle
	assign take = (avs_read_in || avs_write_in) && (st_q.bus == UNMC_IDLE);
	assign addr = avs_address_in;
	assign stat_rd = take && avs_read_in && (addr == {1'b0, unmc_pkg::IRQ_STAT_OFS});
	assign mask_wr = take && avs_write_in && (addr == unmc_pkg::IRQ_MASK_ADDR)
		&& avs_byteenable_in[0];

	// interrupt events
	assign irq_ev[unmc_pkg::IRQ_NAK]      = |usb_ev_in.nak_sent;
	assign irq_ev[unmc_pkg::IRQ_ZLP_DONE] = usb_ev_in.zlp_sent && st_q.zero_length_pending;
	assign irq_ev[unmc_pkg::IRQ_SETUP]    = usb_ev_in.setup_rx;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_d = st_q;
		st_d.waitreq = 1'b1;
		// bus handshake: idle takes, ack answers with waitrequest low
		unique case (st_q.bus)
			UNMC_IDLE: begin
				if (take) begin
					st_d.bus = UNMC_ACK;
					st_d.waitreq = 1'b0;
					st_d.rdata = 32'h0000_0000;
					if (avs_read_in) begin
						unique case (addr)
							{1'b0, unmc_pkg::NAK_FLAG_OFS}: begin
								st_d.rdata[7:1] = st_q.nak_flags;
							end
							{1'b0, unmc_pkg::NAK_MASK_OFS}: begin
								st_d.rdata[7:1] = st_q.nak_pin_mask_bits;
							end
							{1'b0, unmc_pkg::EP0_SIZE_OFS}: begin
								st_d.rdata[unmc_pkg::ZLP_PEND_BIT] = st_q.zero_length_pending;
								st_d.rdata[unmc_pkg::FIFO_VALID_BIT] = st_q.fifo_valid;
								st_d.rdata[6:0] = st_q.max_pkt;
							end
							{1'b0, unmc_pkg::IRQ_STAT_OFS}: begin
								st_d.rdata[unmc_pkg::IRQ_W-1:0] = irq_stat;
							end
							unmc_pkg::IRQ_MASK_ADDR: begin
								st_d.rdata[unmc_pkg::IRQ_W-1:0] = irq_mask;
							end
							default: begin
								st_d.rdata = 32'h0000_0000;
							end
						endcase
					end
				end
			end
			UNMC_ACK: begin
				st_d.bus = UNMC_IDLE;
			end
		endcase

		// nak flags: software writes 1 to clear, each nak sets (set wins)
		if (take && avs_write_in && addr == {1'b0, unmc_pkg::NAK_FLAG_OFS}
			&& avs_byteenable_in[0]) begin
			st_d.nak_flags = st_q.nak_flags & ~avs_writedata_in[7:1];
		end
		st_d.nak_flags = st_d.nak_flags | usb_ev_in.nak_sent;

		// mask bits
		if (take && avs_write_in && addr == {1'b0, unmc_pkg::NAK_MASK_OFS}
			&& avs_byteenable_in[0]) begin
			st_d.nak_pin_mask_bits = avs_writedata_in[7:1];
		end

		// max packet size
		if (take && avs_write_in && addr == {1'b0, unmc_pkg::EP0_SIZE_OFS}
			&& avs_byteenable_in[0]) begin
			st_d.max_pkt = avs_writedata_in[6:0];
		end

		// zero-length pending: clear on send, set by command (set wins)
		if (usb_ev_in.zlp_sent) begin
			st_d.zero_length_pending = 1'b0;
		end
		if (take && avs_write_in && addr == unmc_pkg::CMD_ADDR && avs_byteenable_in[0]
			&& avs_writedata_in[7:0] == unmc_pkg::CMD_SEND_ZLP_EP0) begin
			st_d.zero_length_pending = 1'b1;
		end

		// fifo valid follows fill state, setup token forces zero
		st_d.fifo_valid = usb_ev_in.fifo_has_data && !usb_ev_in.setup_rx;

		// nak pin level from new flags and mask
		st_d.nak_pin = |(st_d.nak_flags & ~st_d.nak_pin_mask_bits);
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			st_q <= '{
				bus:                 UNMC_IDLE,
				rdata:               32'h0000_0000,
				waitreq:             1'b1,
				nak_flags:           7'h00,
				nak_pin_mask_bits:   unmc_pkg::MASK_RST,
				zero_length_pending: 1'b0,
				fifo_valid:          1'b0,
				max_pkt:             unmc_pkg::MAXPKT_RST,
				nak_pin:             1'b0
			};
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt block

	unmc_irq u_irq (
		.core_clk_in  (core_clk_in),
		.rstn_in      (rstn_in),
		.event_in     (irq_ev),
		.stat_rd_in   (stat_rd),
		.mask_wr_in   (mask_wr),
		.mask_data_in (avs_writedata_in[unmc_pkg::IRQ_W-1:0]),
		.stat_out     (irq_stat),
		.mask_out     (irq_mask),
		.irq_out      (irq_level)
	);

	// outputs
	assign avs_readdata_out    = st_q.rdata;
	assign avs_waitrequest_out = st_q.waitreq;
	assign nak_irq_pin_out     = st_q.nak_pin;
	assign irq_out             = irq_level;

endmodule : unmc_ctrl

// [tb/unmc_ctrl_asserts.sv]
module unmc_ctrl_asserts (
	// clock and reset
	input wire logic                   core_clk_in,
	input wire logic                   rstn_in,
	// bus
	input wire logic [4:0]             avs_address_in,
	input wire logic                   avs_read_in,
	input wire logic                   avs_write_in,
	input wire logic [31:0]            avs_writedata_in,
	input wire logic [3:0]             avs_byteenable_in,
	input wire logic [31:0]            avs_readdata_out,
	input wire logic                   avs_waitrequest_out,
	// usb side and pins
	input wire unmc_pkg::unmc_usb_ev_t usb_ev_in,
	input wire logic                   nak_irq_pin_out,
	input wire logic                   irq_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic ev;
	logic rdok;
	// causes of a pin change, and a read being answered
	assign ev = |usb_ev_in.nak_sent | usb_ev_in.setup_rx | usb_ev_in.zlp_sent | avs_write_in;
	assign rdok = !avs_waitrequest_out && avs_read_in;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);
	a_ack_once: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
		else $error("ack too long");
	a_ack_soon: assert property ($rose(avs_read_in) || $rose(avs_write_in) |-> ##[1:2] !avs_waitrequest_out)
		else $error("ack missing");
	a_ack_cause: assert property ($fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in))
		else $error("ack unasked");
	a_unmapped_zero: assert property (rdok && avs_address_in > 5'h14 |-> avs_readdata_out == 32'h0)
		else $error("unmapped data");
	a_size_gap_zero: assert property (rdok && avs_address_in == 5'h08 |-> avs_readdata_out[11:7] == 5'h00)
		else $error("size gap");
	a_pin_rise: assert property ($rose(nak_irq_pin_out) |-> $past(ev) || $past(ev, 2))
		else $error("pin rose alone");
	a_pin_fall: assert property ($fell(nak_irq_pin_out) |-> $past(avs_write_in) || $past(avs_write_in, 2))
		else $error("pin fell alone");
	a_irq_rise: assert property ($rose(irq_out) |-> $past(ev) || $past(ev, 2))
		else $error("irq rose alone");
	a_irq_fall: assert property ($fell(irq_out) |-> $past(avs_read_in || avs_write_in))
		else $error("irq fell alone");
	// main scenarios
	c_pin: cover property ($rose(nak_irq_pin_out));
	c_irq: cover property ($rose(irq_out));
	c_zlp: cover property (rdok && avs_readdata_out[15]);
endmodule : unmc_ctrl_asserts

bind unmc_ctrl unmc_ctrl_asserts unmc_ctrl_asserts_inst (
	.core_clk_in(core_clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
	.avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out), .usb_ev_in(usb_ev_in),
	.nak_irq_pin_out(nak_irq_pin_out), .irq_out(irq_out));

// [tb/unmc_usb_model.sv]
module unmc_usb_model (
	// clock
	input wire logic               core_clk_in,
	// events toward the block
	output unmc_pkg::unmc_usb_ev_t usb_ev_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// quiet link
	initial usb_ev_out = 10'h000;
	// one-cycle transfer events
	task automatic pulse(input logic [7:1] nak, input logic setup, input logic zlp);
		@(posedge core_clk_in);
		usb_ev_out.nak_sent <= nak;
		usb_ev_out.setup_rx <= setup;
		usb_ev_out.zlp_sent <= zlp;
		@(posedge core_clk_in);
		usb_ev_out.nak_sent <= 7'h00;
		usb_ev_out.setup_rx <= 1'h0;
		usb_ev_out.zlp_sent <= 1'h0;
	endtask : pulse
	// fifo fill level
	task automatic fill(input logic v);
		@(posedge core_clk_in);
		usb_ev_out.fifo_has_data <= v;
	endtask : fill
endmodule : unmc_usb_model

// [tb/test_usb_nak_mask_ctrl_ep_size.sv]
module test_usb_nak_mask_ctrl_ep_size;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk_in, rstn_in, avs_read_in, avs_write_in, avs_waitrequest_out;
	logic nak_irq_pin_out, irq_out;
	logic [4:0] avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out;
	logic [7:0] b;
	unmc_pkg::unmc_usb_ev_t usb_ev;
	int err_count, compares;
	unmc_ctrl unmc_ctrl_inst (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.usb_ev_in(usb_ev), .nak_irq_pin_out(nak_irq_pin_out), .irq_out(irq_out));
	unmc_usb_model unmc_usb_model_inst (.core_clk_in(core_clk_in), .usb_ev_out(usb_ev));
	// compare and count
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// one bus transfer, held until waitrequest is sampled low
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge core_clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_read_in <= !w;
		avs_write_in <= w;
		do begin @(posedge core_clk_in); end while (avs_waitrequest_out !== 1'h0);
		q = avs_readdata_out;
		avs_read_in <= 1'h0;
		avs_write_in <= 1'h0;
	endtask : acc
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'h1, a, d, q);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(1'h0, a, 32'h0, q);
		chk($sformatf("read %h", a), q, e);
	endtask : rd
	// pins after they settle
	task automatic pins(input logic p, input logic i);
		repeat (3) @(posedge core_clk_in);
		chk("nak pin", 32'(nak_irq_pin_out), 32'(p));
		chk("irq", 32'(irq_out), 32'(i));
	endtask : pins
	task automatic end_of_test;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test
	// clock
	initial begin
		core_clk_in = 1'h0;
		forever #12.5 core_clk_in = ~core_clk_in;
	end
	// watchdog
	initial begin
		repeat (5000) @(posedge core_clk_in);
		err_count++;
		end_of_test();
	end
	// tests
	initial begin
		{rstn_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = 40'h0;
		err_count = 0;
		compares = 0;
		repeat (2) @(posedge core_clk_in);
		rstn_in <= 1'h1;
		rd(5'h08, 32'h0);
		rd(5'h04, 32'h0);
		wr(5'h08, 32'hffffffff);
		rd(5'h08, 32'h7f);
		wr(5'h14, 32'h7);
		for (int e = 1; e < 8; e++) begin
			b = 8'h01 << e;
			wr(5'h04, 32'(8'hfe ^ b));
			unmc_usb_model_inst.pulse(b[7:1], 1'h0, 1'h0);
			pins(1'h1, 1'h0);
			wr(5'h00, 32'(b));
			pins(1'h0, 1'h0);
			unmc_usb_model_inst.pulse(~b[7:1], 1'h0, 1'h0);
			pins(1'h0, 1'h0);
			rd(5'h00, 32'(8'hfe ^ b));
			wr(5'h00, 32'hfe);
		end
		rd(5'h0c, 32'h1);
		rd(5'h0c, 32'h0);
		wr(5'h14, 32'h0);
		wr(5'h04, 32'h0);
		unmc_usb_model_inst.pulse(7'h04, 1'h0, 1'h0);
		pins(1'h1, 1'h1);
		rd(5'h0c, 32'h1);
		pins(1'h1, 1'h0);
		wr(5'h00, 32'hfe);
		pins(1'h0, 1'h0);
		wr(5'h10, 32'h1);
		rd(5'h08, 32'h807f);
		unmc_usb_model_inst.pulse(7'h00, 1'h0, 1'h1);
		rd(5'h08, 32'h7f);
		rd(5'h0c, 32'h2);
		unmc_usb_model_inst.fill(1'h1);
		rd(5'h08, 32'h107f);
		unmc_usb_model_inst.fill(1'h0);
		unmc_usb_model_inst.pulse(7'h00, 1'h1, 1'h0);
		rd(5'h08, 32'h7f);
		rd(5'h0c, 32'h4);
		rd(5'h18, 32'h0);
		end_of_test();
	end
endmodule : test_usb_nak_mask_ctrl_ep_size
